// ### src/spife_pkg.sv
// Shared constants and carriers for the serial EEPROM front end.
// Assumes a single system clock domain; serial pins are asynchronous.
package spife_pkg;
    localparam int ARRAY_DEPTH = 16384;     // Storage locations
    localparam int DATA_W      = 8;         // Bits per location
    localparam int ADDR_W      = 14;        // Address bits for the array
    localparam int BITCNT_W    = 3;         // Bit position within a byte
    localparam logic [BITCNT_W-1:0] BIT_LAST = 3'h7; // Eighth bit of a byte
    localparam logic [BITCNT_W-1:0] BIT_FIRST = 3'h0; // First bit of a byte
    localparam logic [DATA_W-1:0]   BYTE_ZERO = 8'h00; // Cleared shift value
    localparam int SYNC_STAGES = 3;         // Pin synchroniser depth

    // Pin group sampled from outside the clock domain
    typedef struct packed {
        logic sclk;        // Serial clock
        logic sdi;         // Serial data in
        logic sel_n;       // Chip select, active low
        logic pause_n;     // Pause input, active low
        logic wprot_n;     // Write protect, active low
    } spife_pins_t;

    // Status bits kept by the front end
    typedef struct packed {
        logic status_lock_bit;   // Non-volatile lock bit
        logic protect_size_hi;   // Non-volatile protect size, high
        logic protect_size_lo;   // Non-volatile protect size, low
        logic write_latch_flag;  // Write enable latch
        logic write_busy_flag;   // Internal write cycle running
    } spife_status_t;

    // Interface state
    typedef enum logic [1:0] {
        SPIFE_ARMING = 2'h0,     // After reset, waiting for high select
        SPIFE_IDLE   = 2'h1,     // Deselected, ready for a falling select
        SPIFE_ACTIVE = 2'h3,     // Selected, shifting bits
        SPIFE_PAUSED = 2'h2      // Selected, in pause condition
    } spife_state_t;
endpackage : spife_pkg

// ### src/spife_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the input is asynchronous to clk.
module spife_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic async_in,
    input  wire logic rst_val,
    output logic      sync_out
);
    import spife_pkg::*;

    logic [SYNC_STAGES-1:0] stage_ff;   // Stage 0 feeds only stage 1
    logic                   sync_ff;    // Filtered level
    wire                    agree = stage_ff[1] == stage_ff[2];

    // Shift the pin through the chain every edge, reset included, so a
    // level held since power-up is settled when reset lets go
    always_ff @(posedge clk) begin
        stage_ff <= {stage_ff[SYNC_STAGES-2:0], async_in};
    end

    // Accept a change only once stages two and three agree; in reset the
    // filter takes the pin level when stages agree, else rst_val, since a select held low from power-up
    // must not look like a falling edge once reset releases
    always_ff @(posedge clk) begin
        if (srst) begin
            sync_ff <= agree ? stage_ff[SYNC_STAGES-1] : rst_val;
        end else if (agree) begin
            sync_ff <= stage_ff[2];
        end
    end

    assign sync_out = sync_ff;
endmodule : spife_sync

// ### src/spife_front.sv
// Serial front end of a 16384 x 8 EEPROM: select, pause, bit shifting,
// power-on state. Assumes srst models power-on reset and that the
// instruction decoder sits outside, fed by rx_byte and feeding tx_byte.
// How it works
// - Array is 16384 bytes of eight bits
// - Input bits sampled on serial clock rise
// - Output bits change after serial clock fall
// - Selected only while select low; active power
// - Select high deselects and floats output
// - Deselected means standby unless write running
// - Need select falling edge after power-up
// - Pause suspends shifting, resumes where stopped
// - Paused: output floats, clock and data ignored
// - Pause only entered while selected
// - Write protect freezes block protect size
// - No response before power-on reset releases
// - Reset: standby, deselected, clear latch, busy
// - Reset keeps lock and protect bits
// - Pause edges count only while clock low
// - Select high during pause resets interface
// - Execute only if select rises after last bit
module spife_front (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire spife_pkg::spife_pins_t  pins,
    input  wire logic [spife_pkg::DATA_W-1:0] tx_byte,
    input  wire logic                    set_latch,
    input  wire logic                    clr_latch,
    input  wire logic                    write_start,
    input  wire logic                    write_done,
    input  wire logic                    nv_load,
    input  wire logic [2:0]              nv_value,
    output logic                         sdo,
    output logic                         sdo_oe,
    output logic [spife_pkg::DATA_W-1:0] rx_byte,
    output logic                         rx_valid,
    output logic                         tx_take,
    output logic                         cmd_end,
    output logic                         selected,
    output logic                         paused,
    output logic                         standby,
    output logic                         nv_frozen,
    output spife_pkg::spife_status_t     status
);
    import spife_pkg::*;

    spife_pins_t   s;                   // Synchronised pin levels
    spife_state_t  state_ff, nxt_state;
    logic          sclk_q_ff;           // Previous serial clock level
    logic          pause_q_ff;          // Previous pause level
    logic [BITCNT_W-1:0] bit_ff;        // Bit position in current byte
    logic [DATA_W-1:0]   shin_ff;       // Incoming shifter
    logic [DATA_W-1:0]   shout_ff;      // Outgoing shifter
    logic          byte_done_ff;        // Last bit of a byte was sampled
    logic          sdo_ff, sdo_oe_ff, rx_valid_ff, tx_take_ff, cmd_end_ff;
    logic          wlatch_ff, wbusy_ff;
    logic [2:0]    nv_ff;               // Lock, protect hi, protect lo
    logic          nv_init_ff;          // Non-volatile bits seen once

    // One synchroniser per pin, idle levels high except clock and data
    localparam spife_pins_t PIN_IDLE = '{sclk: 1'b0, sdi: 1'b0,
        sel_n: 1'b1, pause_n: 1'b1, wprot_n: 1'b1};
    genvar gi;
    generate
        for (gi = 0; gi < $bits(spife_pins_t); gi++) begin : g_sync
            spife_sync u_sync (
                .clk      (clk),
                .srst     (srst),
                .async_in (pins[gi]),
                .rst_val  (PIN_IDLE[gi]),
                .sync_out (s[gi])
            );
        end
    endgenerate

    // Edge detection on the sampled serial clock and pause
    wire sclk_rise  = s.sclk & ~sclk_q_ff;
    wire sclk_fall  = ~s.sclk & sclk_q_ff;
    wire in_sel     = state_ff == SPIFE_ACTIVE;
    wire pause_fall = ~s.pause_n & pause_q_ff & ~s.sclk;
    wire pause_rise = s.pause_n & ~pause_q_ff & ~s.sclk;
    wire shift_in   = in_sel & sclk_rise;
    wire shift_out  = in_sel & sclk_fall;
    // Select rising after the last bit and before the next rise
    wire exec_now   = in_sel & s.sel_n & byte_done_ff;
    wire hw_frozen  = nv_ff[2] & ~s.wprot_n;
    wire dev_sel    = (state_ff == SPIFE_ACTIVE) |
                      (state_ff == SPIFE_PAUSED);

    // Next interface state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            // Wait for select high before any falling edge counts
            SPIFE_ARMING: if (s.sel_n) nxt_state = SPIFE_IDLE;
            SPIFE_IDLE:   if (~s.sel_n) nxt_state = SPIFE_ACTIVE;
            SPIFE_ACTIVE: begin
                if (s.sel_n) begin
                    nxt_state = SPIFE_IDLE;
                end else if (pause_fall) begin
                    nxt_state = SPIFE_PAUSED;
                end
            end
            SPIFE_PAUSED: begin
                // Deselect during pause drops the whole sequence
                if (s.sel_n) begin
                    nxt_state = SPIFE_IDLE;
                end else if (pause_rise) begin
                    nxt_state = SPIFE_ACTIVE;
                end
            end
        endcase
    end

    // State and edge history; reset lands in the arming state
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff   <= SPIFE_ARMING;
            sclk_q_ff  <= 1'b0;
            pause_q_ff <= 1'b1;
        end else begin
            state_ff   <= nxt_state;
            sclk_q_ff  <= s.sclk;
            pause_q_ff <= s.pause_n;
        end
    end

    // Input shifter and bit counter; frozen while paused
    always_ff @(posedge clk) begin
        if (srst || !dev_sel || s.sel_n) begin
            bit_ff       <= BIT_FIRST;
            shin_ff      <= BYTE_ZERO;
            byte_done_ff <= 1'b0;
        end else if (shift_in) begin
            shin_ff      <= {shin_ff[DATA_W-2:0], s.sdi};
            bit_ff       <= bit_ff + 3'h1;
            byte_done_ff <= bit_ff == BIT_LAST;
        end
    end

    // Received byte strobe, one cycle after the eighth bit
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_byte     <= BYTE_ZERO;
            rx_valid_ff <= 1'b0;
            cmd_end_ff  <= 1'b0;
        end else begin
            rx_valid_ff <= shift_in & (bit_ff == BIT_LAST);
            if (shift_in & (bit_ff == BIT_LAST)) begin
                rx_byte <= {shin_ff[DATA_W-2:0], s.sdi};
            end
            cmd_end_ff  <= exec_now;
        end
    end

    // Output shifter: loads at byte start, moves only on a falling clock
    always_ff @(posedge clk) begin
        if (srst || !dev_sel) begin
            shout_ff   <= BYTE_ZERO;
            sdo_ff     <= 1'b0;
            tx_take_ff <= 1'b0;
        end else begin
            tx_take_ff <= shift_out & (bit_ff == BIT_FIRST);
            if (shift_out) begin
                // Loading at bit 0 lets the decoder refresh tx_byte per byte
                if (bit_ff == BIT_FIRST) begin
                    sdo_ff   <= tx_byte[DATA_W-1];
                    shout_ff <= {tx_byte[DATA_W-2:0], 1'b0};
                end else begin
                    sdo_ff   <= shout_ff[DATA_W-1];
                    shout_ff <= {shout_ff[DATA_W-2:0], 1'b0};
                end
            end
        end
    end

    // Output drive only while selected and not paused
    always_ff @(posedge clk) begin
        if (srst) begin
            sdo_oe_ff <= 1'b0;
        end else begin
            sdo_oe_ff <= (nxt_state == SPIFE_ACTIVE);
        end
    end

    // Volatile status bits; set wins over clear on the latch
    always_ff @(posedge clk) begin
        if (srst) begin
            wlatch_ff <= 1'b0;
            wbusy_ff  <= 1'b0;
        end else begin
            if (set_latch) begin
                wlatch_ff <= 1'b1;
            end else if (clr_latch) begin
                wlatch_ff <= 1'b0;
            end
            if (write_start) begin
                wbusy_ff <= 1'b1;
            end else if (write_done) begin
                wbusy_ff <= 1'b0;
            end
        end
    end

    // Non-volatile bits are untouched by reset; the first load seeds them
    always_ff @(posedge clk) begin
        if (srst) begin
            nv_init_ff <= 1'b0;
        end else if (nv_load && (!nv_init_ff || !hw_frozen)) begin
            nv_init_ff <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (nv_load && (!nv_init_ff || !hw_frozen)) begin
            nv_ff <= nv_value;
        end
    end

    // Registered flags for the outside world
    always_ff @(posedge clk) begin
        if (srst) begin
            selected  <= 1'b0;
            paused    <= 1'b0;
            standby   <= 1'b1;
            nv_frozen <= 1'b0;
            // Lock and protect bits ride through reset untouched
            status    <= '{status_lock_bit: nv_ff[2],
                           protect_size_hi: nv_ff[1],
                           protect_size_lo: nv_ff[0],
                           write_latch_flag: 1'b0,
                           write_busy_flag: 1'b0};
        end else begin
            selected  <= (nxt_state == SPIFE_ACTIVE) |
                         (nxt_state == SPIFE_PAUSED);
            paused    <= nxt_state == SPIFE_PAUSED;
            // Busy write keeps active power after deselect
            standby   <= ~dev_sel & ~wbusy_ff;
            nv_frozen <= hw_frozen;
            status    <= '{status_lock_bit: nv_ff[2],
                           protect_size_hi: nv_ff[1],
                           protect_size_lo: nv_ff[0],
                           write_latch_flag: wlatch_ff,
                           write_busy_flag: wbusy_ff};
        end
    end

    // Address space of the array is ADDR_W bits for ARRAY_DEPTH bytes
    assign sdo      = sdo_ff;
    assign sdo_oe   = sdo_oe_ff;
    assign rx_valid = rx_valid_ff;
    assign tx_take  = tx_take_ff;
    assign cmd_end  = cmd_end_ff;
endmodule : spife_front

// ### testbench/spife_checker.sv
// Port assertions for spife_front, bound into every instance.
// Assumes srst models power-on reset; pins pass a 3-4 clock synchroniser.
module spife_checker (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire spife_pkg::spife_pins_t   pins,
    input wire logic                     sdo_oe,
    input wire logic                     cmd_end,
    input wire logic                     selected,
    input wire logic                     paused,
    input wire logic                     standby,
    input wire logic                     nv_frozen,
    input wire spife_pkg::spife_status_t status
);
    import spife_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_OE_GATED:
    assert property (sdo_oe |-> selected && !paused)
        else $error("output driven while deselected or paused");
    AST_PAUSE_SEL: assert property (paused |-> selected)
        else $error("paused while deselected");
    AST_SEL_PIN: assert property ($rose(selected) |-> !pins.sel_n)
        else $error("selected with select pin high");
    AST_DESEL: assert property (pins.sel_n [*7] |-> !selected)
        else $error("still selected after select went high");
    AST_ACTIVE: assert property (selected [*3] |-> !standby)
        else $error("standby while selected");
    // Pin term keeps the check clear of the select synchroniser lag
    AST_STANDBY:
    assert property ((!selected && pins.sel_n && !status.write_busy_flag) [*3]
        |-> standby) else $error("no standby when idle");
    AST_BUSY:
    assert property (status.write_busy_flag [*2] |-> !standby)
        else $error("standby during write cycle");
    AST_RESET:
    assert property ($fell(srst) |-> standby && !selected
        && !status.write_latch_flag && !status.write_busy_flag)
        else $error("wrong state after reset");
    AST_CMD_END: assert property (cmd_end |-> ##[0:2] !selected)
        else $error("execute pulse while still selected");
    AST_FROZEN:
    assert property ((status.status_lock_bit && !pins.wprot_n) [*6]
        |-> nv_frozen) else $error("protect bits not frozen");
    cover property (cmd_end);
    cover property (paused);
    cover property (nv_frozen);
endmodule : spife_checker

bind spife_front spife_checker u_chk (.clk, .srst, .pins, .sdo_oe,
    .cmd_end, .selected, .paused, .standby, .nv_frozen, .status);

// ### testbench/spife_master.sv
// Serial bus master model: clock, data, select, pause and protect pins.
// Assumes tasks start just after a clk edge; clock phases are 400 ns.
module spife_master
    import spife_pkg::*;
(
    output spife_pkg::spife_pins_t pins,
    input  wire logic              sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // Select starts low to probe power-up behaviour
    initial pins = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    // Shift n bits MSB first from bit hi; sdo read late in high phase
    task automatic shift(input int hi, input int n, input logic [7:0] tx,
                         output logic [7:0] rx);
        rx = 8'h00;
        for (int i = hi; i > hi - n; i--) begin
            pins.sdi = tx[i];
            #400 pins.sclk = 1'b1;
            #398 rx[i] = sdo; // Read off the clk edge
            #2 pins.sclk = 1'b0;
        end
        pins.sdi = ~pins.sdi; // Released line must not look like data
    endtask : shift
    // Select moves only with the clock low, after the last rise
    task automatic sel(input logic lvl);
        #400 pins.sel_n = lvl;
        #600;
    endtask : sel
    // Pause moves only with the clock low, whether or not the device is selected
    task automatic hold(input logic lvl);
        #400 pins.pause_n = lvl;
        #600;
    endtask : hold
    // Protect level is set between frames only
    task automatic prot(input logic lvl);
        pins.wprot_n = lvl;
    endtask : prot
endmodule : spife_master

// ### testbench/test_spife_front.sv
// Self-checking bench for spife_front driven by a serial master model.
// Assumes clk at 10 MHz; stimulus lands 1 ns after each rising edge.
module test_spife_front
    import spife_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk, srst, sdo, sdo_oe, rx_valid, cmd_end, tx_take;
    logic              set_latch, clr_latch, write_start, write_done;
    logic              nv_load, selected, paused, standby, nv_frozen;
    logic [2:0]        nv_value;
    logic [DATA_W-1:0] tx_byte, rx_byte, b, r, e;
    spife_pins_t       pins;
    spife_status_t     status;
    logic [7:0]        exp_q[$];
    int                n_fail = 0, checks_done = 0, n_cmd = 0, n_take = 0;
    logic [31:0]       seed = 32'h0000003F;
    wire               q_line = sdo_oe ? sdo : 1'bz;
    // Flag bundle: latch, busy, frozen, selected, standby, oe, paused
    wire [7:0] flags = {1'b0, status[1:0], nv_frozen, selected, standby,
                        sdo_oe, paused};
    spife_front u_dut (.clk, .srst, .pins, .tx_byte, .set_latch, .clr_latch,
        .write_start, .write_done, .nv_load, .nv_value, .sdo, .sdo_oe,
        .rx_byte, .rx_valid, .tx_take, .cmd_end, .selected, .paused,
        .standby, .nv_frozen, .status);
    spife_master u_m (.pins, .sdo(q_line));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    task automatic chk(input string what, input logic [7:0] ex, got);
        checks_done++;
        if (got !== ex) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, ex, got);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    // Falling edge sampling keeps clear of the register updates
    always @(negedge clk) begin
        if (rx_valid === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
            chk("rx", e, rx_byte);
        end
        if (cmd_end === 1'b1) n_cmd++;
        if (tx_take === 1'b1) n_take++;
    end
    initial begin
        #300_000;
        n_fail++;
        conclude();
    end
    initial begin
        {set_latch, clr_latch, write_start, write_done, nv_load} = 5'h00;
        nv_value = 3'h4;
        tx_byte = rnd();
        srst = 1'b1;
        tick(8);
        srst = 1'b0;
        pulse(nv_load);
        tick(10);
        chk("flags", 8'h04, flags);
        u_m.sel(1'b1);
        u_m.prot(1'b0);
        nv_value = 3'(rnd());
        tick(8);
        pulse(nv_load);
        tick(2);
        chk("flags", 8'h14, flags);
        chk("nv", 8'h04, {5'h00, status[4:2]});
        u_m.prot(1'b1);
        nv_value = 3'h3;
        tick(8);
        pulse(nv_load);
        tick(2);
        chk("nv", 8'h03, {5'h00, status[4:2]});
        // Two bytes in one frame; the reply rides on the second
        u_m.sel(1'b0);
        chk("flags", 8'h0A, flags);
        repeat (2) begin
            b = rnd();
            exp_q.push_back(b);
            u_m.shift(7, 8, b, r);
        end
        chk("sdo", tx_byte, r);
        u_m.sel(1'b1);
        chk("flags", 8'h04, flags);
        chk("cmds", 8'h01, n_cmd[7:0]);
        chk("takes", 8'h02, n_take[7:0]);
        // Pause mid-byte with clock noise, then finish the byte
        u_m.sel(1'b0);
        b = rnd();
        exp_q.push_back(b);
        u_m.shift(7, 4, b, r);
        u_m.hold(1'b0);
        chk("flags", 8'h09, flags);
        u_m.shift(7, 3, ~b, r);
        u_m.hold(1'b1);
        u_m.shift(3, 4, b, r);
        // A partial byte is dropped when deselected during a pause
        u_m.shift(7, 3, rnd(), r);
        u_m.hold(1'b0);
        u_m.sel(1'b1);
        u_m.hold(1'b1);
        chk("flags", 8'h04, flags);
        chk("cmds", 8'h01, n_cmd[7:0]);
        u_m.sel(1'b0);
        b = rnd();
        exp_q.push_back(b);
        u_m.shift(7, 8, b, r);
        u_m.sel(1'b1);
        chk("cmds", 8'h02, n_cmd[7:0]);
        // Write cycle holds off standby; reset clears volatile bits only
        u_m.sel(1'b0);
        pulse(set_latch);
        pulse(write_start);
        u_m.sel(1'b1);
        chk("flags", 8'h60, flags);
        pulse(write_done);
        pulse(clr_latch);
        tick(4);
        chk("flags", 8'h04, flags);
        pulse(set_latch);
        pulse(write_start);
        srst = 1'b1;
        tick(4);
        chk("flags", 8'h04, flags);
        chk("nv", 8'h03, {5'h00, status[4:2]});
        srst = 1'b0;
        tick(2);
        chk("flags", 8'h04, flags);
        chk("nv", 8'h03, {5'h00, status[4:2]});
        chk("pending", 8'h00, 8'(exp_q.size()));
        conclude();
    end
endmodule : test_spife_front
